//--- stack_isa_decoder.sv
// opcode decoder and executor for the stack processor, apb register access
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "stack_isa_decoder_regs.svh"

module stack_isa_decoder
  import stack_isa_decoder_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [31:0] prdata,
  // decoded actions
  output var  logic        issue,
  output var  logic [7:0]  pop_mask,
  output var  logic        push_en,
  output var  logic [2:0]  push_sel,
  output var  logic [31:0] push_data,
  output var  logic [15:0] pc_next,
  output var  logic        mem_rd,
  output var  logic        mem_wr,
  output var  logic        reg_rd,
  output var  logic        reg_wr,
  output var  logic [15:0] mem_addr,
  output var  logic [15:0] mem_wdata,
  output var  logic        alu_op
);
  import stack_isa_decoder_pkg::*;

  state_s s_q;
  state_s s_d;

  logic [7:0] a_hot;
  logic [7:0] b_hot;

  // one-hot stack selects with their pop bits
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sel
      assign a_hot[gi] = s_q.opcode[`F_PA_BIT] &
        (s_q.opcode[`F_A_LSB +: 3] == 3'(gi));
      assign b_hot[gi] = s_q.opcode[`F_PB_BIT] &
        (s_q.opcode[`F_B_LSB +: 3] == 3'(gi));
    end
  endgenerate

  always_comb begin
    logic [15:0] op;
    logic [31:0] a;
    logic [31:0] b;
    logic [15:0] im4s;
    logic [15:0] im6s;
    logic [31:0] im6d;
    logic [5:0]  ndist;
    logic        test;
    logic        wr_en;
    logic        hit;
    logic [31:0] rd;
    logic [31:0] st;
    cls_e        cls;
    s_d   = s_q;
    op    = s_q.opcode;
    a     = s_q.opa;
    b     = s_q.opb;
    im4s  = {{12{op[11]}}, op[`F_IM4_LSB +: 4]};
    im6s  = {{10{op[9]}}, op[`F_IM6_LSB +: 6]};
    im6d  = {{26{op[9]}}, op[`F_IM6_LSB +: 6]};
    ndist = 6'(-op[9:4]);
    test  = 1'b0;
    cls   = C_ALU;
    hit   = 1'b1;
    rd    = `RST_WORD;
    st    = `RST_WORD;
    wr_en = psel & penable & s_q.pready & pwrite;

    // instruction class
    casez (op[15:12])
      4'b1110: cls = C_JIZ;
      4'b1111: begin
        case (op[11:10])
          2'b00:   cls = C_DAT;
          2'b01:   cls = C_ADDI;
          2'b10:   cls = C_SHLI;
          default: cls = C_PSUI;
        endcase
      end
      4'b1???: cls = C_JAB;
      4'b01??: cls = C_MEM;
      4'b0011: begin
        casez (op[11:8])
          4'b00??: cls = C_JZ;
          4'b1100: cls = C_JZ;
          4'b1101: cls = C_GTO;
          4'b1110: cls = C_GSB;
          default: cls = C_ALU;
        endcase
      end
      4'b0000: begin
        casez (op[11:8])
          4'b0000: cls = C_NOP;
          4'b0001: cls = C_POP;
          4'b0100: cls = C_PGC;
          4'b1000: cls = C_LIT;
          4'b1001: cls = C_LIT;
          4'b1010: cls = C_LIT;
          4'b11??: cls = C_REG;
          default: cls = C_ALU;
        endcase
      end
      default: cls = C_ALU;
    endcase

    // status word
    st[7:0]                 = s_q.pop_mask;
    st[`ST_PUSH]            = s_q.push_en;
    st[`ST_PUSH_SEL +: 3]   = s_q.push_sel;
    st[`ST_MEM_RD]          = s_q.mem_rd;
    st[`ST_MEM_WR]          = s_q.mem_wr;
    st[`ST_REG_RD]          = s_q.reg_rd;
    st[`ST_REG_WR]          = s_q.reg_wr;
    st[`ST_HIGH]            = s_q.high;
    st[`ST_TAKEN]           = s_q.taken;
    st[`ST_LIT]             = s_q.lit_used;
    st[`ST_ALU]             = s_q.alu_op;
    st[`ST_DONE]            = s_q.done;

    // apb read mux
    case (paddr[7:0])
      `OFS_OPCODE:    rd = {16'h0000, s_q.opcode};
      `OFS_LITERAL:   rd = {16'h0000, s_q.literal};
      `OFS_OPA:       rd = s_q.opa;
      `OFS_OPB:       rd = s_q.opb;
      `OFS_PC:        rd = {16'h0000, s_q.pc};
      `OFS_RDATA:     rd = {16'h0000, s_q.rdata};
      `OFS_RESULT:    rd = s_q.push_data;
      `OFS_NEXT_PC:   rd = {16'h0000, s_q.pc_next};
      `OFS_STATUS:    rd = st;
      `OFS_MEM_ADDR:  rd = {16'h0000, s_q.mem_addr};
      `OFS_MEM_WDATA: rd = {16'h0000, s_q.mem_wdata};
      default:        hit = 1'b0;
    endcase
    if (paddr[31:8] != 24'h000000) begin
      hit = 1'b0;
    end

    // one wait state, then answer
    if (psel && penable && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.prdata  = hit ? rd : `RST_WORD;
      s_d.pslverr = ~hit;
    end else begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end

    s_d.issue = 1'b0;

    // execute the opcode written in the previous access
    if (s_q.pend) begin
      s_d.pend      = 1'b0;
      s_d.done      = 1'b1;
      s_d.issue     = 1'b1;
      s_d.taken     = 1'b0;
      s_d.high      = 1'b0;
      s_d.lit_used  = 1'b0;
      s_d.push_en   = 1'b0;
      s_d.push_sel  = op[`F_A_LSB +: 3];
      s_d.push_data = `RST_WORD;
      s_d.pc_next   = s_q.pc;
      s_d.mem_rd    = 1'b0;
      s_d.mem_wr    = 1'b0;
      s_d.reg_rd    = 1'b0;
      s_d.reg_wr    = 1'b0;
      s_d.mem_addr  = 16'h0000;
      s_d.mem_wdata = 16'h0000;
      s_d.alu_op    = 1'b0;
      s_d.pop_mask  = a_hot | b_hot;
      case (cls)
        C_NOP: begin
          s_d.pop_mask = 8'h00;
        end
        C_POP: begin
          s_d.pop_mask = op[7:0];
        end
        C_PGC: begin
          s_d.push_en   = 1'b1;
          s_d.push_data = {16'h0000, s_q.pc};
        end
        C_LIT: begin
          s_d.lit_used = 1'b1;
          s_d.push_en  = 1'b1;
          s_d.high     = op[8];
          s_d.pc_next  = 16'(s_q.pc + 16'h0001);
          if (op[8]) begin
            s_d.push_data = {s_q.literal, a[15:0]};
          end else if (op[9]) begin
            s_d.push_data = {16'h0000, s_q.literal};
          end else begin
            s_d.push_data = {{16{s_q.literal[15]}}, s_q.literal};
          end
        end
        C_REG: begin
          s_d.high     = op[8];
          s_d.mem_addr = b[15:0];
          if (op[9]) begin
            s_d.reg_wr    = 1'b1;
            s_d.mem_wdata = op[8] ? a[31:16] : a[15:0];
          end else begin
            s_d.reg_rd    = 1'b1;
            s_d.push_en   = 1'b1;
            s_d.push_data = op[8] ? {s_q.rdata, a[15:0]} :
                            {{16{s_q.rdata[15]}}, s_q.rdata};
          end
        end
        C_JZ: begin
          test = op[9] ? a[31] : (a == `RST_WORD);
          if (op[11:8] == 4'hc) begin
            s_d.taken = 1'b1;
          end else begin
            s_d.taken = test ^ op[8];
          end
          if (s_d.taken) begin
            s_d.pc_next = 16'(s_q.pc + b[15:0]);
          end
        end
        C_GTO: begin
          s_d.taken   = 1'b1;
          s_d.pc_next = b[15:0];
        end
        C_GSB: begin
          s_d.taken     = 1'b1;
          s_d.pc_next   = b[15:0];
          s_d.push_en   = 1'b1;
          s_d.push_data = {16'h0000, s_q.pc};
        end
        C_MEM: begin
          s_d.high     = op[12];
          s_d.mem_addr = 16'(b[15:0] +
                             {12'h000, op[`F_IM4_LSB +: 4]});
          if (op[13]) begin
            s_d.mem_wr    = 1'b1;
            s_d.mem_wdata = op[12] ? a[31:16] : a[15:0];
          end else begin
            s_d.mem_rd    = 1'b1;
            s_d.push_en   = 1'b1;
            s_d.push_data = op[12] ? {s_q.rdata, a[15:0]} :
                            {{16{s_q.rdata[15]}}, s_q.rdata};
          end
        end
        C_JAB: begin
          case (op[14:13])
            2'b00:   test = (a == b);
            2'b01:   test = ($signed(a) < $signed(b));
            default: test = (a < b);
          endcase
          s_d.taken = test ^ op[12];
          if (s_d.taken) begin
            s_d.pc_next = 16'(s_q.pc + im4s);
          end
        end
        C_JIZ: begin
          test      = op[11] ? a[31] : (a == `RST_WORD);
          s_d.taken = test ^ op[10];
          s_d.pop_mask = a_hot;
          if (s_d.taken) begin
            s_d.pc_next = 16'(s_q.pc + im6s);
          end
        end
        C_DAT: begin
          s_d.pop_mask  = a_hot;
          s_d.push_en   = 1'b1;
          s_d.push_data = im6d;
        end
        C_ADDI: begin
          s_d.pop_mask  = a_hot;
          s_d.push_en   = 1'b1;
          s_d.push_data = 32'(a + im6d);
        end
        C_SHLI: begin
          s_d.pop_mask  = a_hot;
          s_d.push_en   = 1'b1;
          if (op[9]) begin
            s_d.push_data = 32'($signed(a) >>> ndist);
          end else begin
            s_d.push_data = a << op[8:4];
          end
        end
        C_PSUI: begin
          s_d.pop_mask  = a_hot;
          s_d.push_en   = 1'b1;
          if (op[9]) begin
            s_d.push_data = a >> ndist;
          end else begin
            s_d.push_data = 32'h0000_0001 << op[8:4];
          end
        end
        default: begin
          s_d.alu_op = 1'b1;
        end
      endcase
    end

    // register writes take effect at the completing edge
    if (wr_en && hit) begin
      case (paddr[7:0])
        `OFS_OPCODE: begin
          s_d.opcode = pwdata[15:0];
          s_d.pend   = 1'b1;
          s_d.done   = 1'b0;
        end
        `OFS_LITERAL: s_d.literal = pwdata[15:0];
        `OFS_OPA:     s_d.opa     = pwdata;
        `OFS_OPB:     s_d.opb     = pwdata;
        `OFS_PC:      s_d.pc      = pwdata[15:0];
        `OFS_RDATA:   s_d.rdata   = pwdata[15:0];
        default:      s_d.pend    = s_d.pend;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign prdata    = s_q.prdata;
  assign issue     = s_q.issue;
  assign pop_mask  = s_q.pop_mask;
  assign push_en   = s_q.push_en;
  assign push_sel  = s_q.push_sel;
  assign push_data = s_q.push_data;
  assign pc_next   = s_q.pc_next;
  assign mem_rd    = s_q.mem_rd;
  assign mem_wr    = s_q.mem_wr;
  assign reg_rd    = s_q.reg_rd;
  assign reg_wr    = s_q.reg_wr;
  assign mem_addr  = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign alu_op    = s_q.alu_op;

endmodule : stack_isa_decoder
`default_nettype wire

//--- stack_isa_decoder_regs.svh
// register offsets, field positions and opcode fields of the decoder
`ifndef STACK_ISA_DECODER_REGS_SVH
`define STACK_ISA_DECODER_REGS_SVH

`define OFS_OPCODE     8'h00
`define OFS_LITERAL    8'h04
`define OFS_OPA        8'h08
`define OFS_OPB        8'h0c
`define OFS_PC         8'h10
`define OFS_RDATA      8'h14
`define OFS_RESULT     8'h18
`define OFS_NEXT_PC    8'h1c
`define OFS_STATUS     8'h20
`define OFS_MEM_ADDR   8'h24
`define OFS_MEM_WDATA  8'h28

`define ST_PUSH        8
`define ST_PUSH_SEL    9
`define ST_MEM_RD      12
`define ST_MEM_WR      13
`define ST_REG_RD      14
`define ST_REG_WR      15
`define ST_HIGH        16
`define ST_TAKEN       17
`define ST_LIT         18
`define ST_ALU         19
`define ST_DONE        20

`define F_A_LSB        0
`define F_PA_BIT       3
`define F_B_LSB        4
`define F_PB_BIT       7
`define F_IM4_LSB      8
`define F_IM6_LSB      4

`define RST_WORD       32'h0000_0000

`endif

//--- stack_isa_decoder_pkg.sv
// types shared by the stack instruction decoder
package stack_isa_decoder_pkg;

  typedef enum logic [15:0] {
    C_NOP  = 16'h0001,
    C_POP  = 16'h0002,
    C_PGC  = 16'h0004,
    C_LIT  = 16'h0008,
    C_REG  = 16'h0010,
    C_ALU  = 16'h0020,
    C_JZ   = 16'h0040,
    C_GTO  = 16'h0080,
    C_GSB  = 16'h0100,
    C_MEM  = 16'h0200,
    C_JAB  = 16'h0400,
    C_JIZ  = 16'h0800,
    C_DAT  = 16'h1000,
    C_ADDI = 16'h2000,
    C_SHLI = 16'h4000,
    C_PSUI = 16'h8000
  } cls_e;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] opcode;
    logic [15:0] literal;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [15:0] pc;
    logic [15:0] rdata;
    logic        pend;
    logic        done;
    logic        taken;
    logic        high;
    logic        lit_used;
    logic        issue;
    logic [7:0]  pop_mask;
    logic        push_en;
    logic [2:0]  push_sel;
    logic [31:0] push_data;
    logic [15:0] pc_next;
    logic        mem_rd;
    logic        mem_wr;
    logic        reg_rd;
    logic        reg_wr;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic        alu_op;
  } state_s;

endpackage : stack_isa_decoder_pkg

//--- stack_isa_decoder_asserts.sv
// concurrent checks on the decoder apb and decode ports
`timescale 1ns/1ps
`default_nettype none
module stack_isa_decoder_asserts (
  // clock, reset and apb
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // decode results
  input wire logic        issue,
  input wire logic [7:0]  pop_mask,
  input wire logic        push_en,
  input wire logic [2:0]  push_sel,
  input wire logic [31:0] push_data,
  input wire logic [15:0] pc_next,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        reg_wr,
  input wire logic [15:0] mem_addr
);
  logic        wr;
  logic        ex;
  logic [31:0] ob_q;
  logic [15:0] pc_q;
  assign wr = psel && penable && pready && pwrite;
  assign ex = wr && paddr == 32'h0000_0000;
  // shadow copies of operand b and the counter as written
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ob_q <= 32'h0;
      pc_q <= 16'h0;
    end else begin
      if (wr && paddr == 32'h0000_000c) ob_q <= pwdata;
      if (wr && paddr == 32'h0000_0010) pc_q <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_issue;
    ex |=> !issue ##1 issue ##1 !issue;
  endproperty
  a_issue: assert property (p_issue) else $error("no issue pulse");
  property p_nop;
    ex && pwdata[15:8] == 8'h00 |=> ##1 pop_mask == 8'h00 && !push_en
      && !mem_rd && !mem_wr && !reg_wr;
  endproperty
  a_nop: assert property (p_nop) else $error("nop has effect");
  property p_pop;
    ex && pwdata[15:8] == 8'h01 |=> ##1 pop_mask == $past(pwdata[7:0], 2);
  endproperty
  a_pop: assert property (p_pop) else $error("pop mask wrong");
  property p_dat;
    ex && pwdata[15:10] == 6'b111100 |=> ##1 push_en
      && push_sel == $past(pwdata[2:0], 2)
      && push_data == {{26{$past(pwdata[9], 2)}}, $past(pwdata[9:4], 2)};
  endproperty
  a_dat: assert property (p_dat) else $error("data push wrong");
  property p_mem;
    ex && pwdata[15:14] == 2'b01 |=> ##1 mem_wr == $past(pwdata[13], 2)
      && mem_rd != $past(pwdata[13], 2)
      && mem_addr == ob_q[15:0] + {12'h0, $past(pwdata[11:8], 2)};
  endproperty
  a_mem: assert property (p_mem) else $error("memory access wrong");
  property p_zpop;
    ex && pwdata[15:12] == 4'he |=> ##1 pop_mask ==
      ($past(pwdata[3], 2) ? 8'h01 << $past(pwdata[2:0], 2) : 8'h00);
  endproperty
  a_zpop: assert property (p_zpop) else $error("zero jump pops");
  property p_gto;
    ex && pwdata[15:8] == 8'h3d |=> ##1 pc_next == ob_q[15:0] && !push_en;
  endproperty
  a_gto: assert property (p_gto) else $error("goto target wrong");
  property p_gsb;
    ex && pwdata[15:8] == 8'h3e |=> ##1 pc_next == ob_q[15:0] && push_en
      && push_data == {16'h0, pc_q};
  endproperty
  a_gsb: assert property (p_gsb) else $error("call wrong");
endmodule : stack_isa_decoder_asserts
bind stack_isa_decoder stack_isa_decoder_asserts stack_isa_decoder_asserts_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .issue(issue), .pop_mask(pop_mask), .push_en(push_en),
  .push_sel(push_sel), .push_data(push_data), .pc_next(pc_next),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .reg_wr(reg_wr), .mem_addr(mem_addr));
`default_nettype wire

//--- main_mem_model.sv
// shared code and data memory beside the decoder
`timescale 1ns/1ps
`default_nettype none
module main_mem_model (
  input wire logic        clk_sys,
  input wire logic        issue,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata
);
  logic [15:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 16'(i) ^ 16'h5a3c;
    end
  end
  // one store per executed instruction, on its issue cycle
  always @(posedge clk_sys) begin
    if (issue && mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
  function automatic logic [15:0] peek(input logic [15:0] a);
    return mem[a];
  endfunction : peek
endmodule : main_mem_model
`default_nettype wire

//--- stack_isa_decoder_tb.sv
// self-checking bench for the stack instruction decoder
`timescale 1ns/1ps
`default_nettype none
module stack_isa_decoder_tb;
  import stack_isa_decoder_pkg::*;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        issue, push_en, mem_rd, mem_wr, reg_rd, reg_wr, alu_op, er;
  logic [31:0] paddr, pwdata, prdata, push_data, rd, e_data;
  logic [15:0] pc_next, mem_addr, mem_wdata, e_pc;
  logic [7:0]  pop_mask, e_mask;
  logic [2:0]  push_sel;
  logic        e_push;
  int          bad_count, compares;
  logic [15:0] ctab [26] = '{16'h00ff, 16'h01a5, 16'h048b, 16'h0899,
    16'h0977, 16'h0a88, 16'h0c12, 16'h0e34, 16'h308f, 16'h3198, 16'h3211,
    16'h33ff, 16'h3c00, 16'h3d88, 16'h3e19, 16'h4a5d, 16'h7b2a, 16'h8f00,
    16'ha123, 16'he7f8, 16'hf5f0, 16'hf600, 16'hfdf0, 16'hfe00, 16'hfbf0,
    16'h20b3};
  stack_isa_decoder stack_isa_decoder_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .issue(issue), .pop_mask(pop_mask), .push_en(push_en),
    .push_sel(push_sel), .push_data(push_data), .pc_next(pc_next),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .alu_op(alu_op));
  main_mem_model main_mem_model_inst (.clk_sys(clk_sys), .issue(issue),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      print_verdict();
    end
  endtask : apb
  task automatic run(input logic [15:0] op, input logic [31:0] a, b,
                     input logic [15:0] pc);
    logic [15:0] lit, rdw, tg;
    logic [31:0] im, ar;
    logic        t;
    logic [4:0]  e_acc;
    int          n;
    lit = main_mem_model_inst.peek(pc);
    rdw = main_mem_model_inst.peek(b[15:0] + {12'h0, op[11:8]});
    im = {{26{op[9]}}, op[9:4]};
    ar = $signed(a) >>> -im;
    e_mask = op[3] ? 8'h01 << op[2:0] : 8'h00;
    if (op[15:12] < 4'he && op[7]) e_mask = e_mask | 8'h01 << op[6:4];
    e_push = 1'b0;
    e_data = {16'h0, pc};
    e_pc = pc;
    t = 1'b0;
    tg = pc + b[15:0];
    if (op[15:8] == 8'h00) e_mask = 8'h00;
    else if (op[15:8] == 8'h01) e_mask = op[7:0];
    else if (op[15:8] == 8'h04) e_push = 1'b1;
    else if (op[15:10] == 6'h02 && op[15:8] != 8'h0b) begin
      e_push = 1'b1;
      e_pc = pc + 16'h1;
      e_data = op[8] ? {lit, a[15:0]} : op[9] ? {16'h0, lit} :
        {{16{lit[15]}}, lit};
    end else if (op[15:10] == 6'h03 && !op[9] || op[15:13] == 3'b010) begin
      e_push = 1'b1;
      e_data = (op[14] ? op[12] : op[8]) ? {rdw, a[15:0]} :
        {{16{rdw[15]}}, rdw};
    end else if (op[15:10] == 6'h0c) t = (op[9] ? a[31] : a == 0) ^ op[8];
    else if (op[15:8] == 8'h3c) t = 1'b1;
    else if (op[15:8] == 8'h3d || op[15:8] == 8'h3e) begin
      t = 1'b1;
      tg = b[15:0];
      e_push = op[9];
    end else if (op[15:12] == 4'hf) begin
      e_push = 1'b1;
      case (op[11:10])
        2'd0: e_data = im;
        2'd1: e_data = a + im;
        2'd2: e_data = im[31] ? ar : a << im;
        default: e_data = im[31] ? a >> -im : 32'h1 << im;
      endcase
    end else if (op[15:12] == 4'he) begin
      t = (op[11] ? a[31] : a == 0) ^ op[10];
      tg = pc + im[15:0];
    end else if (op[15]) begin
      t = (op[14] ? a < b : op[13] ? $signed(a) < $signed(b) : a == b)
        ^ op[12];
      tg = pc + {{12{op[11]}}, op[11:8]};
    end
    if (t) e_pc = tg;
    // access kinds and the ops left to the alu
    e_acc = {op[15:13] == 3'b010, op[15:13] == 3'b011, op[15:9] == 7'h06,
      op[15:9] == 7'h07, 1'b0};
    case (op[15:8])
      8'h00, 8'h01, 8'h04, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
      8'h30, 8'h31, 8'h32, 8'h33, 8'h3c, 8'h3d, 8'h3e: e_acc[0] = 1'b0;
      default: e_acc[0] = op[15:14] == 2'b00;
    endcase
    apb(1'b1, 32'h08, a);
    apb(1'b1, 32'h0c, b);
    apb(1'b1, 32'h10, {16'h0, pc});
    apb(1'b1, 32'h04, {16'h0, lit});
    apb(1'b1, 32'h14, {16'h0, rdw});
    apb(1'b1, 32'h00, {16'h0, op});
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (issue !== 1'b1 && n < 8);
    if (n >= 8) begin
      bad_count++;
      print_verdict();
    end
    chk(32'(pop_mask), 32'(e_mask));
    chk(32'(pc_next), 32'(e_pc));
    chk(32'(push_en), 32'(e_push));
    if (e_push) chk(push_data, e_data);
    if (e_push) chk(32'(push_sel), 32'(op[2:0]));
    chk(32'({mem_rd, mem_wr, reg_rd, reg_wr, alu_op}), 32'(e_acc));
    if (op[15:14] == 2'b01) begin
      chk(32'(mem_addr), 32'(16'(b[15:0] + op[11:8])));
    end
    if (op[15:13] == 3'b011) begin
      @(posedge clk_sys);
      rdw = main_mem_model_inst.peek(mem_addr);
      chk(32'(rdw), 32'(op[12] ? a[31:16] : a[15:0]));
    end
  endtask : run
  initial begin
    logic [31:0] a;
    bad_count = 0;
    compares = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(36345));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, 32'h20, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 32'h30, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset_map done");
    foreach (ctab[i]) begin
      for (int j = 0; j < 3; j++) begin
        a = j == 0 ? 32'h0 : j == 1 ? 32'hffff_ffff : $urandom;
        run(ctab[i], a, j == 2 ? a : 32'(j) - 32'h1, 16'($urandom));
      end
    end
    $display("test corners done");
    repeat (250) begin
      a = $urandom % 4 == 0 ? 32'h0 : $urandom;
      run(16'($urandom), a, $urandom % 4 == 0 ? a : $urandom, 16'($urandom));
    end
    $display("test random done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk(32'(pop_mask), 32'h0);
    $display("test second_reset done");
    print_verdict();
  end
endmodule : stack_isa_decoder_tb
`default_nettype wire
